// ### dv/core_model.sv
// processor-core side model issuing file reads and writes
`timescale 1ns/1ns
module core_model (
  input wire logic ref_clk,
  input wire logic [7:0] file_rdata_reg,
  input wire logic file_rvalid_reg,
  output logic [6:0] file_addr,
  output logic file_rd,
  output logic file_wr,
  output logic [7:0] file_wdata
);
  initial begin
    file_addr = 7'h55;
    file_rd = 1'b0;
    file_wr = 1'b0;
    file_wdata = 8'ha5;
  end
  // idle lines flip so a stale value never looks valid
  task automatic idle_bus();
    file_addr = ~file_addr;
    file_wdata = ~file_wdata;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    file_addr = a;
    file_wdata = d;
    file_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    file_wr = 1'b0;
    idle_bus();
  endtask
  // data only counts in the one cycle that valid stands
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    file_addr = a;
    file_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    file_rd = 1'b0;
    idle_bus();
    @(posedge ref_clk);
    #1;
    d = (file_rvalid_reg === 1'b1) ? file_rdata_reg : 8'hxx;
  endtask
endmodule

// ### dv/sfr_file_bench.sv
// self-checking bench for the special-function register file
`timescale 1ns/1ns
module sfr_file_bench;
  import sfr_file_pkg::*;
  // ----------------------------------------
  // signals and hookup
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] file_addr;
  logic file_rd, file_wr, status_flags_we, in_sleep, master_clear_rst, wdt_timeout, bor_rst, wake_irq, wake_from_cmp;
  logic [7:0] file_wdata, file_rdata_reg, status_reg, file_select_pointer_reg;
  logic [7:0] timer_and_port_options_reg, second_port_direction_reg;
  logic [2:0] status_flags_in;
  logic [12:0] pc_cur, pc_target_reg;
  logic file_rvalid_reg, pc_load_reg, vector_pending_reg, peripheral_irq_flag_reg;
  logic [4:0] first_port_direction_reg;
  logic [1:0] power_control_flags_reg;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] lfsr = 8'h2a;
  logic [7:0] m_st, d, g, p;
  logic [7:0] second_port_data_reg, m_pb;
  logic [1:0] m_pc;
  logic m_pir;
  always #5 ref_clk = ~ref_clk;
  sfr_file dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .status_flags_we(status_flags_we),
    .status_flags_in(status_flags_in), .pc_cur(pc_cur), .in_sleep(in_sleep), .master_clear_rst(master_clear_rst),
    .wdt_timeout(wdt_timeout), .bor_rst(bor_rst), .wake_irq(wake_irq), .wake_from_cmp(wake_from_cmp),
    .file_rdata_reg(file_rdata_reg), .file_rvalid_reg(file_rvalid_reg), .pc_load_reg(pc_load_reg),
    .pc_target_reg(pc_target_reg), .vector_pending_reg(vector_pending_reg), .status_reg(status_reg),
    .file_select_pointer_reg(file_select_pointer_reg), .timer_zero_count_reg(), .first_port_data_reg(),
    .second_port_data_reg(second_port_data_reg), .program_counter_high_latch_reg(), .interrupt_control_reg(),
    .peripheral_irq_flag_reg(peripheral_irq_flag_reg), .comparator_control_reg(),
    .timer_and_port_options_reg(timer_and_port_options_reg), .first_port_direction_reg(first_port_direction_reg),
    .second_port_direction_reg(second_port_direction_reg), .peripheral_irq_enable_reg(),
    .power_control_flags_reg(power_control_flags_reg), .voltage_reference_control_reg());
  core_model core (.ref_clk(ref_clk), .file_rdata_reg(file_rdata_reg), .file_rvalid_reg(file_rvalid_reg),
    .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // status write: to/pd bits stay read-only
  task automatic wst(input logic [7:0] w);
    core.wr(7'h03, w);
    m_st = {w[7:5], m_st[4:3], w[2:0]};
    chk("status_wr", m_st, status_reg);
  endtask
  task automatic flags();
    d = rnd();
    @(posedge ref_clk);
    #1;
    status_flags_in = d[2:0];
    status_flags_we = 1'b1;
    @(posedge ref_clk);
    #1;
    status_flags_we = 1'b0;
    m_st[2:0] = d[2:0];
  endtask
  // k: 0 master_clear run, 1 master_clear sleep, 2 wdt run, 3 wdt wake, 4 brown-out, 5 cmp wake gie, 6 wake no gie
  task automatic ev(input int k);
    logic [7:0] s;
    logic global_interrupt_enable;
    logic wake;
    s = m_st;
    global_interrupt_enable = (k == 5);
    wake = (k == 3 || k >= 5);
    if (k >= 5) core.wr(7'h0b, {global_interrupt_enable, 7'h00});
    d = rnd();
    @(posedge ref_clk);
    #1;
    pc_cur = {d[4:0], rnd()};
    in_sleep = (k == 1 || wake);
    wake_from_cmp = (k == 5);
    master_clear_rst = (k < 2);
    wdt_timeout = (k == 2 || k == 3);
    bor_rst = (k == 4);
    wake_irq = (k >= 5);
    @(posedge ref_clk);
    #1;
    {master_clear_rst, wdt_timeout, bor_rst, wake_irq} = 4'h0;
    in_sleep = 1'b0;
    case (k)
      0: m_st = {3'b000, s[4:0]};
      1: m_st = {5'b00010, s[2:0]};
      2: m_st = {4'b0000, s[3:0]};
      3: m_st = {s[7:5], 2'b00, s[2:0]};
      4: m_st = {5'b00011, s[2:0]};
      default: m_st = {s[7:5], 2'b10, s[2:0]};
    endcase
    if (k == 4) m_pc[0] = 1'b0;
    if (!wake) m_pir = 1'b0;
    if (k == 5) m_pir = 1'b1;
    chk("status_ev", m_st, status_reg);
    chk("pc_load", 1, pc_load_reg);
    chk("pc_target", wake ? 13'(pc_cur + 13'h1) : 13'h0, pc_target_reg);
    chk("vector", global_interrupt_enable, vector_pending_reg);
    chk("power_control_flags", m_pc, power_control_flags_reg);
    chk("pir6", m_pir, peripheral_irq_flag_reg);
    if (!wake) chk("option", 8'hff, timer_and_port_options_reg);
    if (!wake) chk("second_port_direction", 8'hff, second_port_direction_reg);
    chk("second_port_data", m_pb, second_port_data_reg);
  endtask
  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {status_flags_we, in_sleep, master_clear_rst, wdt_timeout, bor_rst, wake_irq, wake_from_cmp} = 7'h00;
    status_flags_in = 3'h0;
    pc_cur = 13'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    p = 8'h00;
    repeat (2) begin
      if (pc_load_reg === 1'b1 && pc_target_reg === 13'h0) p = 8'h01;
      @(posedge ref_clk);
      #1;
    end
    chk("pc_load_por", 1, p);
    chk("status_por", 8'h18, status_reg);
    chk("power_control_flags_por", 2'h0, power_control_flags_reg);
    chk("option_por", 8'hff, timer_and_port_options_reg);
    chk("second_port_direction_por", 8'hff, second_port_direction_reg);
    chk("first_port_direction_por", 5'h1f, first_port_direction_reg);
    m_st = 8'h18;
    m_pir = 1'b0;
    wst(8'h20);
    core.wr(7'h0e, 8'h03);
    core.wr(7'h01, 8'h00);
    core.wr(7'h06, 8'h00);
    wst(8'h00);
    m_pc = 2'b11;
    chk("power_control_flags_wr", m_pc, power_control_flags_reg);
    chk("option_wr", 8'h00, timer_and_port_options_reg);
    // bank bit set: decode must still use the pointer alone
    wst(8'h80);
    repeat (4) begin
      p = 8'h20 + rnd() % 8'd96;
      d = rnd();
      core.wr(7'h04, p);
      core.wr(7'h00, d);
      core.rd(7'h00, g);
      chk("ind_rd", d, g);
      core.rd(p[6:0], g);
      chk("direct_rd", d, g);
    end
    foreach (p[i]) begin
      if (i < 2) begin
        core.wr(7'h04, {i[0], 7'h00});
        core.wr(7'h00, 8'h5a);
        core.rd(7'h00, g);
        chk("self_rd", 8'h00, g);
        chk("self_ptr", {i[0], 7'h00}, file_select_pointer_reg);
        chk("self_status", m_st, status_reg);
      end
    end
    core.wr(7'h07, 8'hff);
    core.rd(7'h07, g);
    chk("unmapped", 8'h00, g);
    m_pb = rnd();
    core.wr(7'h06, m_pb);
    for (int k = 0; k < 7; k++) begin
      wst(rnd() & 8'hdf);
      flags();
      ev(k);
    end
    finish_test();
  end
endmodule

// ### hdl/gpr_ram.sv
// general-purpose data memory with registered read data
`timescale 1ns/1ns
module gpr_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data_reg
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end
endmodule

// ### hdl/sfr_file.sv
// special-function register file with indirect access and reset initialisation
// Notes on behaviour
// - indirect port reads/writes location at pointer
// - indirect read of port itself returns 00h
// - indirect write to port itself stores nothing
// - effective address: rp0 bit above direct address
// - bank bit unused; pointer alone decodes
// - power-on: pc 000h, status 18h, flags 0x
// - master clear running: status 000u uuuu
// - master clear sleeping: status 0001 0uuu
// - interrupt wake: pc+1, status uuu1 0uuu
// - wake with global enable: vector 0004h after
// - port-b direction and options reset to ffh
// - brown-out clears bor flag, others keep it
// - comparator wake sets peripheral flag bit 6
`timescale 1ns/1ns
`include "sfr_file_regs.svh"
module sfr_file
  import sfr_file_pkg::*;
#(
  parameter bit GPR_BANK1 = 1'b1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [6:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  input wire logic status_flags_we,
  input wire logic [2:0] status_flags_in,
  input wire logic [12:0] pc_cur,
  input wire logic in_sleep,
  input wire logic master_clear_rst,
  input wire logic wdt_timeout,
  input wire logic bor_rst,
  input wire logic wake_irq,
  input wire logic wake_from_cmp,
  output logic [7:0] file_rdata_reg,
  output logic file_rvalid_reg,
  output logic pc_load_reg,
  output logic [12:0] pc_target_reg,
  output logic vector_pending_reg,
  output logic [7:0] status_reg,
  output logic [7:0] file_select_pointer_reg,
  output logic [7:0] timer_zero_count_reg,
  output logic [4:0] first_port_data_reg,
  output logic [7:0] second_port_data_reg,
  output logic [4:0] program_counter_high_latch_reg,
  output logic [7:0] interrupt_control_reg,
  output logic peripheral_irq_flag_reg,
  output logic [5:0] comparator_control_reg,
  output logic [7:0] timer_and_port_options_reg,
  output logic [4:0] first_port_direction_reg,
  output logic [7:0] second_port_direction_reg,
  output logic peripheral_irq_enable_reg,
  output logic [1:0] power_control_flags_reg,
  output logic [7:0] voltage_reference_control_reg
);
  // ----------------------------------------
  // event decode
  // ----------------------------------------
  reset_event_e ev;
  logic any_rst;
  // brown-out outranks master clear, which outranks the watchdog
  always_comb begin
    ev = EV_NONE;
    if (bor_rst) begin
      ev = EV_BOR;
    end else if (master_clear_rst) begin
      ev = in_sleep ? EV_MASTER_CLEAR_SLP : EV_MASTER_CLEAR_RUN;
    end else if (wdt_timeout) begin
      ev = in_sleep ? EV_WAKE_WDT : EV_WDT_RST;
    end else if (wake_irq && in_sleep) begin
      ev = EV_WAKE_IRQ;
    end
  end

  assign any_rst = (ev == EV_BOR) || (ev == EV_MASTER_CLEAR_RUN) || (ev == EV_MASTER_CLEAR_SLP) || (ev == EV_WDT_RST);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic indirect;
  logic [7:0] eff_addr;
  logic self_ref;
  logic is_gpr;
  logic wr_ok;
  logic [7:0] sfr_val;

  assign indirect = (file_addr == `OFS_INDIRECT_DATA);
  // bank bit would sit above the pointer; it is unused so the pointer alone decodes
  assign eff_addr = indirect ? file_select_pointer_reg : {status_reg[`STATUS_RP0_BIT], file_addr};
  assign self_ref = indirect && (file_select_pointer_reg[6:0] == `OFS_INDIRECT_DATA);
  assign is_gpr = ((eff_addr >= `GPR_BANK0_FIRST) && (eff_addr <= `GPR_BANK0_LAST)) ||
                  (GPR_BANK1 && (eff_addr >= `GPR_BANK1_FIRST) && (eff_addr <= `GPR_BANK1_LAST));
  assign wr_ok = file_wr && !self_ref && !any_rst && !sys_rst;
  always_comb begin
    sfr_val = 8'h00;
    if (self_ref) begin
      sfr_val = 8'h00;
    end else begin
      unique case (eff_addr[6:0])
        `OFS_PC_LOW: sfr_val = pc_cur[7:0];
        `OFS_STATUS: sfr_val = status_reg;
        `OFS_FILE_SELECT: sfr_val = file_select_pointer_reg;
        `OFS_PC_HIGH_LATCH: sfr_val = {3'h0, program_counter_high_latch_reg};
        `OFS_INTR_CONTROL: sfr_val = interrupt_control_reg;
        default: sfr_val = 8'h00;
      endcase
      unique case (eff_addr)
        8'h01: sfr_val = timer_zero_count_reg;
        `OFS_PORT_DATA_A: sfr_val = {3'h0, first_port_data_reg};
        `OFS_PORT_DATA_B: sfr_val = second_port_data_reg;
        `OFS_PERIPH_FLAGS: sfr_val = {1'b0, peripheral_irq_flag_reg, 6'h00};
        `OFS_COMPARATOR: sfr_val = {2'h0, comparator_control_reg};
        `OFS_OPTIONS: sfr_val = timer_and_port_options_reg;
        `OFS_PORT_DIR_A: sfr_val = {3'h0, first_port_direction_reg};
        `OFS_PORT_DIR_B: sfr_val = second_port_direction_reg;
        `OFS_PERIPH_ENABLES: sfr_val = {1'b0, peripheral_irq_enable_reg, 6'h00};
        `OFS_POWER_FLAGS: sfr_val = {6'h00, power_control_flags_reg};
        `OFS_VOLT_REF: sfr_val = {voltage_reference_control_reg[7:5], 1'b0, voltage_reference_control_reg[3:0]};
        default: ;
      endcase
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  function automatic logic hit_m(input logic [7:0] a, input logic [6:0] ofs);
    hit_m = (a[6:0] == ofs);
  endfunction

  // ----------------------------------------
  // data memory and read pipeline
  // ----------------------------------------
  logic ram_we;
  logic [7:0] ram_q;
  logic rd_pend_reg;
  logic rd_gpr_reg;
  logic [7:0] rd_sfr_reg;

  assign ram_we = wr_ok && is_gpr;

  gpr_ram #(.DATA_W(8), .ADDR_W(8)) u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_we),
    .wr_addr(eff_addr),
    .wr_data(file_wdata),
    .rd_en(file_rd),
    .rd_addr(eff_addr),
    .rd_data_reg(ram_q)
  );

  // two-stage read so the returned byte leaves from a flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      rd_gpr_reg <= 1'b0;
      rd_sfr_reg <= 8'h00;
      file_rvalid_reg <= 1'b0;
      file_rdata_reg <= 8'h00;
    end else begin
      rd_pend_reg <= file_rd;
      rd_gpr_reg <= is_gpr && !self_ref;
      rd_sfr_reg <= sfr_val;
      file_rvalid_reg <= rd_pend_reg;
      file_rdata_reg <= rd_gpr_reg ? ram_q : rd_sfr_reg;
    end
  end

  // ----------------------------------------
  // program counter redirect
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_load_reg <= 1'b1;
      pc_target_reg <= `RESET_VECTOR;
      vector_pending_reg <= 1'b0;
    end else begin
      pc_load_reg <= 1'b0;
      vector_pending_reg <= 1'b0;
      if (any_rst) begin
        pc_load_reg <= 1'b1;
        pc_target_reg <= `RESET_VECTOR;
      end else if (ev == EV_WAKE_IRQ || ev == EV_WAKE_WDT) begin
        pc_load_reg <= 1'b1;
        pc_target_reg <= pc_t'(pc_cur + 13'h0001);
        // core runs the next instruction, then takes the vector
        vector_pending_reg <= (ev == EV_WAKE_IRQ) && interrupt_control_reg[`INTERRUPT_CONTROL_GIE_BIT];
      end else if (wr_ok && hit_m(eff_addr, `OFS_PC_LOW)) begin
        pc_load_reg <= 1'b1;
        pc_target_reg <= {program_counter_high_latch_reg, file_wdata};
      end
    end
  end

  // ----------------------------------------
  // status and power flags
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_reg <= `STATUS_POR_VAL;
    end else begin
      unique case (ev)
        EV_MASTER_CLEAR_RUN: status_reg <= {3'h0, status_reg[4:0]};
        EV_MASTER_CLEAR_SLP: status_reg <= {5'b00010, status_reg[2:0]};
        EV_WDT_RST: status_reg <= {4'h0, status_reg[3:0]};
        EV_WAKE_WDT: status_reg <= {status_reg[7:5], 2'b00, status_reg[2:0]};
        EV_WAKE_IRQ: status_reg <= {status_reg[7:5], 2'b10, status_reg[2:0]};
        EV_BOR: status_reg <= {5'b00011, status_reg[2:0]};
        EV_NONE: begin
          // to/pd bits are read-only to software; core flags win over a same-cycle write to bits 2:0
          if (wr_ok && hit_m(eff_addr, `OFS_STATUS)) begin
            status_reg <= {file_wdata[7:5], status_reg[4:3], status_flags_we ? status_flags_in : file_wdata[2:0]};
          end else if (status_flags_we) begin
            status_reg[2:0] <= status_flags_in;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      power_control_flags_reg <= `POWER_CONTROL_FLAGS_POR_VAL;
    end else if (ev == EV_BOR) begin
      power_control_flags_reg[`POWER_CONTROL_FLAGS_BOR_BIT] <= 1'b0;
    end else if (ev == EV_NONE && wr_ok && hit(eff_addr, `OFS_POWER_FLAGS)) begin
      power_control_flags_reg <= file_wdata[1:0];
    end
  end

  // ----------------------------------------
  // reset-initialised control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_rst) begin
      timer_and_port_options_reg <= `OPTION_RST_VAL;
      second_port_direction_reg <= `PORT_DIR_B_RST_VAL;
      first_port_direction_reg <= `PORT_DIR_A_RST_VAL;
      program_counter_high_latch_reg <= 5'h00;
      comparator_control_reg <= 6'h00;
      peripheral_irq_enable_reg <= 1'b0;
      voltage_reference_control_reg <= 8'h00;
      interrupt_control_reg <= {7'h00, interrupt_control_reg[0] & !sys_rst}; // bit 0 cleared only at power-on
    end else if (wr_ok) begin
      if (hit(eff_addr, `OFS_OPTIONS)) timer_and_port_options_reg <= file_wdata;
      if (hit(eff_addr, `OFS_PORT_DIR_B)) second_port_direction_reg <= file_wdata;
      if (hit(eff_addr, `OFS_PORT_DIR_A)) first_port_direction_reg <= file_wdata[4:0];
      if (hit_m(eff_addr, `OFS_PC_HIGH_LATCH)) program_counter_high_latch_reg <= file_wdata[4:0];
      if (hit(eff_addr, `OFS_COMPARATOR)) comparator_control_reg <= file_wdata[5:0];
      if (hit(eff_addr, `OFS_PERIPH_ENABLES)) peripheral_irq_enable_reg <= file_wdata[`PIR_CMP_BIT];
      if (hit(eff_addr, `OFS_VOLT_REF)) voltage_reference_control_reg <= file_wdata;
      if (hit_m(eff_addr, `OFS_INTR_CONTROL)) interrupt_control_reg <= file_wdata;
    end
  end

  // data latches survive every reset except power-on
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      file_select_pointer_reg <= 8'h00;
      timer_zero_count_reg <= 8'h00;
      first_port_data_reg <= 5'h00;
      second_port_data_reg <= 8'h00;
    end else if (wr_ok) begin
      if (hit_m(eff_addr, `OFS_FILE_SELECT)) file_select_pointer_reg <= file_wdata;
      if (hit(eff_addr, {1'b0, `OFS_TIMER_ZERO})) timer_zero_count_reg <= file_wdata;
      if (hit(eff_addr, `OFS_PORT_DATA_A)) first_port_data_reg <= file_wdata[4:0];
      if (hit(eff_addr, `OFS_PORT_DATA_B)) second_port_data_reg <= file_wdata;
    end
  end

  // comparator wake sets the flag; the set wins over a same-cycle software clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst || any_rst) begin
      peripheral_irq_flag_reg <= 1'b0;
    end else if (ev == EV_WAKE_IRQ && wake_from_cmp) begin
      peripheral_irq_flag_reg <= 1'b1;
    end else if (wr_ok && hit(eff_addr, `OFS_PERIPH_FLAGS)) begin
      peripheral_irq_flag_reg <= file_wdata[`PIR_CMP_BIT];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic post_por_reg;
  always_ff @(posedge ref_clk) begin
    post_por_reg <= sys_rst;
  end

  property p_ind_route;
    @(posedge ref_clk) disable iff (sys_rst)
      file_wr && indirect && !any_rst && (file_select_pointer_reg >= `GPR_BANK0_FIRST) &&
      (file_select_pointer_reg <= `GPR_BANK0_LAST) |-> ram_we && (eff_addr == file_select_pointer_reg);
  endproperty
  a_ind_route: assert property (p_ind_route) else $error("indirect write not routed to pointer");

  property p_self_read;
    @(posedge ref_clk) disable iff (sys_rst)
      file_rd && self_ref && !any_rst |-> ##2 file_rvalid_reg && (file_rdata_reg == 8'h00);
  endproperty
  a_self_read: assert property (p_self_read) else $error("self indirect read not zero");

  property p_self_write;
    @(posedge ref_clk) disable iff (sys_rst)
      file_wr && self_ref |-> !ram_we ##1 $stable(timer_and_port_options_reg);
  endproperty
  a_self_write: assert property (p_self_write) else $error("self indirect write stored data");

  property p_por;
    @(posedge ref_clk) disable iff (sys_rst)
      post_por_reg |-> status_reg == `STATUS_POR_VAL && power_control_flags_reg[1] == 1'b0 &&
      pc_load_reg && pc_target_reg == `RESET_VECTOR;
  endproperty
  a_por: assert property (p_por) else $error("power-on values wrong");

  property p_master_clear_run;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_MASTER_CLEAR_RUN |=> status_reg[7:5] == 3'h0 && status_reg[4:0] == $past(status_reg[4:0]) &&
      $stable(power_control_flags_reg) && pc_target_reg == `RESET_VECTOR;
  endproperty
  a_master_clear_run: assert property (p_master_clear_run) else $error("master clear while running wrong");

  property p_master_clear_sleep;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_MASTER_CLEAR_SLP |=> status_reg[7:3] == 5'b00010 && status_reg[2:0] == $past(status_reg[2:0]) &&
      $stable(power_control_flags_reg);
  endproperty
  a_master_clear_sleep: assert property (p_master_clear_sleep) else $error("master clear in sleep wrong");

  property p_wake_irq;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_WAKE_IRQ |=> pc_load_reg && pc_target_reg == pc_t'($past(pc_cur) + 13'h0001) &&
      status_reg[4:3] == 2'b10 && $stable(power_control_flags_reg);
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("interrupt wake values wrong");

  property p_vector;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_WAKE_IRQ && interrupt_control_reg[7] |=> vector_pending_reg ##1 !vector_pending_reg;
  endproperty
  a_vector: assert property (p_vector) else $error("vector request missing");

  property p_dir_reset;
    @(posedge ref_clk) disable iff (sys_rst)
      any_rst |=> second_port_direction_reg == 8'hff && timer_and_port_options_reg == 8'hff &&
      $stable(second_port_data_reg);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("port b direction or options not reset");

  property p_wdt;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_WAKE_WDT |=> status_reg[4:3] == 2'b00 && pc_target_reg == pc_t'($past(pc_cur) + 13'h0001);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog wake values wrong");

  property p_bor;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_BOR |=> power_control_flags_reg[0] == 1'b0 &&
      power_control_flags_reg[1] == $past(power_control_flags_reg[1]);
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out flag not cleared");

  property p_cmp;
    @(posedge ref_clk) disable iff (sys_rst)
      ev == EV_WAKE_IRQ && wake_from_cmp |=> peripheral_irq_flag_reg;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator wake flag not set");
endmodule

// ### hdl/sfr_file_pkg.sv
// types shared by the special-function register file
package sfr_file_pkg;
  typedef enum logic [2:0] {
    EV_NONE      = 3'b000,
    EV_WAKE_IRQ  = 3'b001,
    EV_WAKE_WDT  = 3'b011,
    EV_WDT_RST   = 3'b010,
    EV_MASTER_CLEAR_RUN  = 3'b110,
    EV_MASTER_CLEAR_SLP  = 3'b111,
    EV_BOR       = 3'b101
  } reset_event_e;
  typedef logic [12:0] pc_t;
endpackage

// ### hdl/sfr_file_regs.svh
// register offsets, reset values and vectors for the special-function register file
`ifndef SFR_FILE_REGS_SVH
`define SFR_FILE_REGS_SVH

`define OFS_INDIRECT_DATA  7'h00
`define OFS_TIMER_ZERO     7'h01
`define OFS_PC_LOW         7'h02
`define OFS_STATUS         7'h03
`define OFS_FILE_SELECT    7'h04
`define OFS_PORT_DATA_A    8'h05
`define OFS_PORT_DATA_B    8'h06
`define OFS_PC_HIGH_LATCH  7'h0a
`define OFS_INTR_CONTROL   7'h0b
`define OFS_PERIPH_FLAGS   8'h0c
`define OFS_COMPARATOR     8'h1f
`define OFS_OPTIONS        8'h81
`define OFS_PORT_DIR_A     8'h85
`define OFS_PORT_DIR_B     8'h86
`define OFS_PERIPH_ENABLES 8'h8c
`define OFS_POWER_FLAGS    8'h8e
`define OFS_VOLT_REF       8'h9f

`define GPR_BANK0_FIRST    8'h20
`define GPR_BANK0_LAST     8'h7f
`define GPR_BANK1_FIRST    8'ha0
`define GPR_BANK1_LAST     8'hbf

`define STATUS_BANK_BIT    7
`define STATUS_RP0_BIT     5
`define STATUS_TO_BIT      4
`define STATUS_PD_BIT      3
`define INTERRUPT_CONTROL_GIE_BIT     7
`define PIR_CMP_BIT        6
`define POWER_CONTROL_FLAGS_POR_BIT       1
`define POWER_CONTROL_FLAGS_BOR_BIT       0

`define STATUS_POR_VAL     8'h18
`define POWER_CONTROL_FLAGS_POR_VAL       2'h0
`define OPTION_RST_VAL     8'hff
`define PORT_DIR_B_RST_VAL 8'hff
`define PORT_DIR_A_RST_VAL 5'h1f
`define INTR_VECTOR        13'h0004
`define RESET_VECTOR       13'h0000

`endif
